// [hw/scg_gain_rate.sv]
// Self-calibration gain register, gain correction stage and rate decode
// Notes on behaviour
// [R1] A 24-bit host read/write register holds the self-calibration gain value.
// [R2] Serial writes and reads of that register shift the most significant bit first.
// [R3] The gain value is always treated as a two's complement number.
// [R4] A host value stays until rewritten or replaced by a completed self-calibration.
// [R5] Host writes during an active calibration are discarded.
// [R6] With the bypass bit at 0 the offset-corrected result is multiplied by the gain.
// [R7] The gain multiplier scales by up to two times.
// [R8] The corrected result is within two least significant bits of the exact product.
// [R9] With line select 0 the rate codes give the 60 Hz family of rates.
// [R10] With line select 1 the rate codes give the 50 Hz family of rates.
// [R11] The self-calibration offset is subtracted before the gain is applied.
// [R12] System offset is applied after the self corrections, as the last stage.
// [R13] Reset clears the gain register to zero.
`timescale 1ns/100ps
`default_nettype none
module scg_gain_rate
   import scg_pkg::*;
(
   input  wire logic                  i_sys_clk,
   input  wire logic                  i_rst_n,
   input  wire logic                  i_reg_sel,
   input  wire logic                  i_reg_wr,
   input  wire logic                  i_bit_stb,
   input  wire logic                  i_bit_in,
   output logic                       o_bit_out,
   input  wire logic                  i_cal_busy,
   input  wire logic                  i_cal_done,
   input  wire logic [SCG_REG_W-1:0]  i_cal_gain,
   input  wire logic                  i_self_gain_bypass,
   input  wire logic                  i_self_offset_bypass,
   input  wire logic                  i_system_offset_bypass,
   input  wire logic [SCG_REG_W-1:0]  i_self_cal_offset_value,
   input  wire logic [SCG_REG_W-1:0]  i_system_offset_value,
   input  wire logic                  i_raw_vld,
   input  wire logic [SCG_DATA_W-1:0] i_raw_data,
   output logic                       o_corr_vld,
   output logic [SCG_DATA_W-1:0]      o_corr_data,
   output logic [SCG_REG_W-1:0]       o_self_cal_gain_value,
   input  wire logic [SCG_RATE_W-1:0] i_rate,
   input  wire logic                  i_line_freq_select,
   output logic [SCG_MSPS_W-1:0]      o_single_rate_msps,
   output logic [SCG_MSPS_W-1:0]      o_cont_rate_msps,
   output logic                       o_cont_valid
);

   // Two's complement saturation of a wide value to the data width
   function automatic logic [SCG_DATA_W-1:0] sat24(input logic signed [49:0] v);
      logic signed [49:0] hi;
      logic signed [49:0] lo;
      hi = 50'sh7FFFFF;
      lo = -50'sh800000;
      if (v > hi)
         sat24 = 24'h7FFFFF;
      else if (v < lo)
         sat24 = 24'h800000;
      else
         sat24 = v[SCG_DATA_W-1:0];
   endfunction

   // Select, strobe and data inputs pass two flip-flops; the write flag is used unsynced
   logic [1:0] sel_sync_r;
   logic [1:0] stb_sync_r;
   logic [1:0] din_sync_r;
   logic [1:0] sel_sync_nxt;
   logic [1:0] stb_sync_nxt;
   logic [1:0] din_sync_nxt;
   logic       stb_prev_r;
   logic       stb_prev_nxt;

   always_comb
   begin
      sel_sync_nxt = {sel_sync_r[0], i_reg_sel};
      stb_sync_nxt = {stb_sync_r[0], i_bit_stb};
      din_sync_nxt = {din_sync_r[0], i_bit_in};
      stb_prev_nxt = stb_sync_r[1];
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         sel_sync_r <= 2'h0;
         stb_sync_r <= 2'h0;
         din_sync_r <= 2'h0;
         stb_prev_r <= 1'b0;
      end
      else
      begin
         sel_sync_r <= sel_sync_nxt;
         stb_sync_r <= stb_sync_nxt;
         din_sync_r <= din_sync_nxt;
         stb_prev_r <= stb_prev_nxt;
      end
   end

   // Rise of the synced strobe
   logic bit_rise;
   assign bit_rise = stb_sync_r[1] & ~stb_prev_r;

   // Serial port state
   scg_state_t           state_r;
   scg_state_t           state_nxt;
   logic [SCG_REG_W-1:0] shift_r;
   logic [SCG_REG_W-1:0] shift_nxt;
   logic [4:0]           cnt_r;
   logic [4:0]           cnt_nxt;
   logic [SCG_REG_W-1:0] gain_r;
   logic [SCG_REG_W-1:0] gain_nxt;
   logic                 dout_r;
   logic                 dout_nxt;
   // Set once select drops, so one select frame gives one transfer
   logic                 armed_r;
   logic                 armed_nxt;

   always_comb
   begin
      state_nxt = state_r;
      shift_nxt = shift_r;
      cnt_nxt   = cnt_r;
      gain_nxt  = gain_r;
      dout_nxt  = dout_r;
      armed_nxt = armed_r;
      case (state_r)
         SCG_IDLE:
         begin
            cnt_nxt = 5'h00;
            // Start only after select was seen low
            if (!sel_sync_r[1])
               armed_nxt = 1'b1;
            else if (armed_r)
            begin
               armed_nxt = 1'b0;
               if (i_reg_wr)
                  state_nxt = SCG_WRITE;
               else
               begin
                  state_nxt = SCG_READ;
                  shift_nxt = gain_r;
                  // MSB first out
                  dout_nxt  = gain_r[SCG_REG_W-1];
               end
            end
         end
         SCG_WRITE:
         begin
            if (!sel_sync_r[1])
               state_nxt = SCG_IDLE;
            else if (bit_rise)
            begin
               // MSB first in
               shift_nxt = {shift_r[SCG_REG_W-2:0], din_sync_r[1]};
               cnt_nxt   = cnt_r + 5'h01;
               if (cnt_r == 5'(SCG_REG_W - 1))
               begin
                  state_nxt = SCG_IDLE;
                  // [R5] Drop write when busy
                  if (!i_cal_busy)
                     gain_nxt = {shift_r[SCG_REG_W-2:0], din_sync_r[1]};
               end
            end
         end
         SCG_READ:
         begin
            if (!sel_sync_r[1])
               state_nxt = SCG_IDLE;
            else if (bit_rise)
            begin
               // [R2] Shift out MSB first
               shift_nxt = {shift_r[SCG_REG_W-2:0], 1'b0};
               dout_nxt  = shift_r[SCG_REG_W-2];
               cnt_nxt   = cnt_r + 5'h01;
               if (cnt_r == 5'(SCG_REG_W - 1))
                  state_nxt = SCG_IDLE;
            end
         end
         default:
            state_nxt = SCG_IDLE;
      endcase
      // [R4] Calibration result replaces
      if (i_cal_done)
         gain_nxt = i_cal_gain;
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state_r <= SCG_IDLE;
         shift_r <= SCG_GAIN_RST;
         cnt_r   <= 5'h00;
         // [R13] Reset clears gain
         gain_r  <= SCG_GAIN_RST;
         dout_r  <= 1'b0;
         armed_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         shift_r <= shift_nxt;
         cnt_r   <= cnt_nxt;
         // [R1] Gain register store
         gain_r  <= gain_nxt;
         dout_r  <= dout_nxt;
         armed_r <= armed_nxt;
      end
   end

   assign o_bit_out             = dout_r;
   assign o_self_cal_gain_value = gain_r;

   // Correction pipeline
   logic                  vld_r;
   logic                  vld_nxt;
   logic [SCG_DATA_W-1:0] corr_r;
   logic [SCG_DATA_W-1:0] corr_nxt;
   logic signed [49:0]    off_sub;
   logic signed [49:0]    scaled;
   logic signed [49:0]    sys_sub;
   logic signed [49:0]    prod;

   always_comb
   begin
      // [R11] Self offset first
      off_sub = 50'(signed'(i_raw_data));
      if (!i_self_offset_bypass)
         off_sub = off_sub - 50'(signed'(i_self_cal_offset_value));
      // [R3] [R7] Signed gain multiply
      prod = 50'(signed'(sat24(off_sub))) * 50'(signed'(gain_r));
      // [R8] Round to nearest LSB
      scaled = (prod + (50'sd1 <<< (SCG_GAIN_FRAC - 1))) >>> SCG_GAIN_FRAC;
      // [R6] Bypass selects the unscaled offset-corrected path
      if (i_self_gain_bypass)
         scaled = 50'(signed'(sat24(off_sub)));
      // [R12] System offset after self
      sys_sub = 50'(signed'(sat24(scaled)));
      if (!i_system_offset_bypass)
         sys_sub = sys_sub - 50'(signed'(i_system_offset_value));
      vld_nxt  = i_raw_vld;
      // Hold result between pulses
      corr_nxt = i_raw_vld ? sat24(sys_sub) : corr_r;
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         vld_r  <= 1'b0;
         corr_r <= 24'h000000;
      end
      else
      begin
         vld_r  <= vld_nxt;
         corr_r <= corr_nxt;
      end
   end

   assign o_corr_vld  = vld_r;
   assign o_corr_data = corr_r;

   // Rate decode
   logic [SCG_MSPS_W-1:0] sr_nxt;
   logic [SCG_MSPS_W-1:0] cr_nxt;
   logic                  cv_nxt;
   logic [SCG_MSPS_W-1:0] sr_r;
   logic [SCG_MSPS_W-1:0] cr_r;
   logic                  cv_r;

   always_comb
   begin
      // [R9] [R10] Rate table lookup
      sr_nxt = i_line_freq_select ? SCG_SC_50HZ[i_rate] : SCG_SC_60HZ[i_rate];
      cv_nxt = (i_rate >= SCG_RATE_CONT0);
      if (cv_nxt)
         cr_nxt = i_line_freq_select ? SCG_CT_50HZ[i_rate[1:0]] : SCG_CT_60HZ[i_rate[1:0]];
      else
         cr_nxt = 20'h00000;
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         sr_r <= 20'h00000;
         cr_r <= 20'h00000;
         cv_r <= 1'b0;
      end
      else
      begin
         sr_r <= sr_nxt;
         cr_r <= cr_nxt;
         cv_r <= cv_nxt;
      end
   end

   assign o_single_rate_msps = sr_r;
   assign o_cont_rate_msps   = cr_r;
   assign o_cont_valid       = cv_r;

endmodule
`default_nettype wire

// [hw/scg_pkg.sv]
// Constants for the self-calibration gain stage and rate decode
package scg_pkg;
   // Register width and reset value
   localparam int          SCG_REG_W      = 24;
   localparam logic [23:0] SCG_GAIN_RST   = 24'h000000;
   // Gain value: two's complement, unity at 2^22 (range up to 2x)
   localparam int          SCG_GAIN_FRAC  = 22;
   // Result width of the correction path
   localparam int          SCG_DATA_W     = 24;
   // Rate field width
   localparam int          SCG_RATE_W     = 3;
   // First rate code with a continuous rate
   localparam logic [2:0]  SCG_RATE_CONT0 = 3'h4;
   // Rates are reported in milli-samples per second
   localparam int          SCG_MSPS_W     = 20;
   localparam logic [19:0] SCG_SC_60HZ [8] = '{20'h003E8, 20'h009C4, 20'h01388, 20'h02710,
                                               20'h03A98, 20'h07530, 20'h0EA60, 20'h1D4C0};
   localparam logic [19:0] SCG_SC_50HZ [8] = '{20'h00341, 20'h00820, 20'h0104A, 20'h0208A,
                                               20'h030D4, 20'h061A8, 20'h0C350, 20'h186A0};
   localparam logic [19:0] SCG_CT_60HZ [4] = '{20'h0EA60, 20'h1D4C0, 20'h3A980, 20'h75300};
   localparam logic [19:0] SCG_CT_50HZ [4] = '{20'h0C350, 20'h186A0, 20'h30D40, 20'h61A80};
   // Shift states of the serial register port
   typedef enum logic [1:0]
   {
      SCG_IDLE  = 2'b00,
      SCG_WRITE = 2'b01,
      SCG_READ  = 2'b10
   } scg_state_t;
endpackage

// [sim/scg_gain_rate_asserts.sv]
// Port checks for the gain stage and rate decode
`timescale 1ns/100ps
`default_nettype none
module scg_gain_rate_asserts
(
   input wire logic        i_sys_clk,
   input wire logic        i_rst_n,
   input wire logic        i_reg_sel,
   input wire logic        i_cal_busy,
   input wire logic        i_cal_done,
   input wire logic [23:0] i_cal_gain,
   input wire logic        i_self_gain_bypass,
   input wire logic        i_self_offset_bypass,
   input wire logic        i_system_offset_bypass,
   input wire logic        i_raw_vld,
   input wire logic [23:0] i_raw_data,
   input wire logic        o_corr_vld,
   input wire logic [23:0] o_corr_data,
   input wire logic [23:0] o_self_cal_gain_value,
   input wire logic [2:0]  i_rate,
   input wire logic        i_line_freq_select,
   input wire logic [19:0] o_single_rate_msps,
   input wire logic [19:0] o_cont_rate_msps,
   input wire logic        o_cont_valid
);
   wire byp = i_self_offset_bypass & i_system_offset_bypass;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   AST_RST_GAIN: assert property ($rose(i_rst_n) |->
      o_self_cal_gain_value == 24'h000000) else $error("gain not clear");
   AST_CAL_LOAD: assert property (i_cal_done |=>
      o_self_cal_gain_value == $past(i_cal_gain)) else $error("cal gain not loaded");
   AST_GAIN_HOLD: assert property ((!i_cal_done && !i_reg_sel) [*4] |=>
      $stable(o_self_cal_gain_value)) else $error("gain changed idle");
   AST_BUSY_DROP: assert property ((i_cal_busy && !i_cal_done) [*2] |=>
      $stable(o_self_cal_gain_value)) else $error("write during cal");
   AST_UNITY: assert property (i_raw_vld && !i_self_gain_bypass && byp &&
      o_self_cal_gain_value == 24'h400000 |=> o_corr_data == $past(i_raw_data))
      else $error("unity gain changed data");
   AST_CORR_HOLD: assert property (!i_raw_vld |=>
      !o_corr_vld && $stable(o_corr_data)) else $error("result moved");
   AST_RATE_TOP: assert property (i_rate == 3'h7 && !i_line_freq_select |=>
      o_cont_valid && o_cont_rate_msps == 20'h75300) else $error("top rate");
   AST_RATE_LOW: assert property (i_rate == 3'h0 && i_line_freq_select |=>
      !o_cont_valid && o_single_rate_msps == 20'h00341) else $error("low rate");
endmodule
bind scg_gain_rate scg_gain_rate_asserts scg_gain_rate_asserts_i (.*);
`default_nettype wire

// [sim/scg_gain_rate_tb.sv]
// Self-checking bench for the gain stage and rate decode
`timescale 1ns/100ps
`default_nettype none
module scg_gain_rate_tb;
   logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_reg_sel, i_reg_wr, i_bit_stb, i_bit_in;
   logic i_cal_busy = 1'b0, i_cal_done = 1'b0, i_raw_vld = 1'b0, i_line_freq_select = 1'b0;
   logic i_self_gain_bypass = 1'b0, i_self_offset_bypass = 1'b0;
   logic i_system_offset_bypass = 1'b0, o_bit_out, o_corr_vld, o_cont_valid;
   logic [23:0] i_cal_gain = 24'h000000, i_self_cal_offset_value = 24'h000000;
   logic [23:0] i_system_offset_value = 24'h000000, i_raw_data = 24'h000000;
   logic [23:0] o_corr_data, o_self_cal_gain_value, g = 24'h000000, r;
   logic [19:0] o_single_rate_msps, o_cont_rate_msps;
   logic [2:0]  i_rate = 3'h0;
   int n_mismatch = 0, num_checks = 0, cyc = 0, seed = 32'hE603;
   int f60[8] = '{1000, 2500, 5000, 10000, 15000, 30000, 60000, 120000};
   int f50[8] = '{833, 2080, 4170, 8330, 12500, 25000, 50000, 100000};
   scg_gain_rate scg_gain_rate_i (.*);
   scg_host scg_host_i (.i_sys_clk, .i_dout(o_bit_out), .o_sel(i_reg_sel), .o_wr(i_reg_wr),
      .o_stb(i_bit_stb), .o_din(i_bit_in));
   always #25 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         n_mismatch++;
         finish_test();
      end
   end
   task automatic tk(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask
   function automatic longint sx(input logic [23:0] v);
      return longint'(signed'(v));
   endfunction
   function automatic longint sat(input longint v);
      return v > 8388607 ? 8388607 : (v < -8388608 ? -8388608 : v);
   endfunction
   function automatic longint model();
      longint a;
      a = sx(i_raw_data);
      if (!i_self_offset_bypass) a = sat(a - sx(i_self_cal_offset_value));
      if (!i_self_gain_bypass) a = sat((a * sx(g) + 2097152) >>> 22);
      return i_system_offset_bypass ? a : sat(a - sx(i_system_offset_value));
   endfunction
   task automatic chk(input logic [23:0] v, input longint e, input int t);
      num_checks++;
      if ($isunknown(v) || sx(v) - e > t || e - sx(v) > t)
      begin
         n_mismatch++;
         $display("Error %0t: got %h exp %0d", $time, v, e);
      end
   endtask
   task automatic load(input logic [23:0] v);
      i_cal_gain = v;
      i_cal_done = 1'b1;
      tk(1);
      i_cal_done = 1'b0;
      g = v;
      tk(1);
      chk(o_self_cal_gain_value, sx(g), 0);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      tk(12);
      i_rst_n = 1'b1;
      tk(1);
      chk(o_self_cal_gain_value, 0, 0);
      for (int k = 0; k < 16; k++)
      begin
         int f;
         f = k[3] ? f50[k % 8] : f60[k % 8];
         i_rate = k[2:0];
         i_line_freq_select = k[3];
         tk(2);
         chk(o_single_rate_msps, f, 0);
         chk(o_cont_rate_msps, k[2] ? 4 * f : 0, 0);
         chk(o_cont_valid, k[2], 0);
      end
      $display("test rates done");
      for (int k = 0; k < 40; k++)
      begin
         if (k > 7) load(k[3] ? 24'h400000 : (k[4] ? 24'h7FFFFF : 24'($random(seed))));
         {i_self_gain_bypass, i_self_offset_bypass, i_system_offset_bypass} = k[2:0];
         i_raw_data = 24'($random(seed));
         i_self_cal_offset_value = 24'($random(seed) >>> 10);
         i_system_offset_value = 24'($random(seed) >>> 10);
         i_raw_vld = 1'b1;
         tk(1);
         chk(o_corr_vld, 1, 0);
         chk(o_corr_data, model(), 2);
         i_raw_vld = 1'b0;
         tk(1);
      end
      $display("test correction done");
      g = 24'($random(seed));
      scg_host_i.xfer(1'b1, g, 24, r);
      chk(o_self_cal_gain_value, sx(g), 0);
      scg_host_i.xfer(1'b0, 24'h000000, 24, r);
      chk(r, sx(g), 0);
      scg_host_i.xfer(1'b1, ~g, 12, r);
      chk(o_self_cal_gain_value, sx(g), 0);
      i_cal_busy = 1'b1;
      scg_host_i.xfer(1'b1, ~g, 24, r);
      i_cal_busy = 1'b0;
      chk(o_self_cal_gain_value, sx(g), 0);
      load(24'h800000);
      scg_host_i.xfer(1'b0, 24'h000000, 24, r);
      chk(r, sx(g), 0);
      $display("test serial done");
      finish_test();
   end
endmodule
`default_nettype wire

// [sim/scg_host.sv]
// Host model driving the serial gain register port
`timescale 1ns/100ps
`default_nettype none
module scg_host
(
   input  wire logic i_sys_clk,
   input  wire logic i_dout,
   output logic      o_sel = 1'b0,
   output logic      o_wr = 1'b0,
   output logic      o_stb = 1'b0,
   output logic      o_din = 1'b0
);
   task automatic tk(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask
   task automatic xfer(input logic w, input logic [23:0] v, input int nb,
      output logic [23:0] r);
      r = 24'h000000;
      o_sel = 1'b1;
      o_wr = w;
      tk(5);
      for (int i = 23; i > 23 - nb; i--)
      begin
         o_din = w ? v[i] : ~o_din;
         r[i] = i_dout;
         tk(1);
         o_stb = 1'b1;
         tk(4);
         o_stb = 1'b0;
         tk(4);
      end
      o_sel = 1'b0;
      o_din = ~o_din;
      tk(4);
   endtask
endmodule
`default_nettype wire
